// file: logic/ipw_pkg.sv
// Constants shared by the interrupt priority and watchdog logic
package ipw_pkg;
  localparam int IPW_NSRC       = 13;
  localparam int IPW_NEXT       = 6;
  localparam int IPW_LVLW       = 3;
  // Source positions in natural order
  localparam int SRC_PF         = 0;
  localparam int SRC_EX0        = 1;
  localparam int SRC_TM0        = 2;
  localparam int SRC_EX1        = 3;
  localparam int SRC_TM1        = 4;
  localparam int SRC_WD         = 12;
  typedef int ipw_idx_tbl_t [IPW_NEXT];
  localparam ipw_idx_tbl_t IPW_EXT_SRC = '{1, 3, 8, 9, 10, 11};
  typedef logic [7:0] ipw_vec_tbl_t [IPW_NSRC];
  localparam ipw_vec_tbl_t IPW_VEC = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
                                       8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
  localparam logic [2:0] LVL_PF = 3'h4;
  // Watchdog control register fields
  localparam int WDC_RESTART    = 0;
  localparam int WDC_RST_EN     = 1;
  localparam int WDC_WD_FLAG    = 3;
  localparam int WDC_PF_FLAG    = 4;
  localparam int WDC_PF_EN      = 5;
  // Clock control register ratio field
  localparam int CKC_RATIO_LSB  = 6;
  localparam logic [1:0] WD_RATIO_RST = 2'h0;
  // Watchdog timing in system clocks
  localparam int WD_BASE_LOG2   = 17;
  localparam int WD_STEP_LOG2   = 3;
  localparam int WD_RST_LAG     = 512;
endpackage

// file: logic/ipw_wd_if.sv
// Connection between the arbiter top and the watchdog timer
`timescale 1ns/1ns
interface ipw_wd_if;
  logic [1:0] ratio_sel;
  logic       restart;
  logic       reset_en;
  logic       irq_timeout;
  logic       reset_timeout;
  modport top (output ratio_sel, output restart, output reset_en,
               input irq_timeout, input reset_timeout);
  modport wd  (input ratio_sel, input restart, input reset_en,
               output irq_timeout, output reset_timeout);
endinterface

// file: logic/ipw_watchdog.sv
// Watchdog timeout generator: interrupt timeout, then reset timeout
`timescale 1ns/1ns
module ipw_watchdog #(
  parameter int BASE_LOG2 = ipw_pkg::WD_BASE_LOG2
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control and timeouts
  ipw_wd_if.wd      wd
);
  import ipw_pkg::*;

  localparam int CW = BASE_LOG2 + 3 * WD_STEP_LOG2 + 1;

  if (BASE_LOG2 < 10 || CW > 40) begin : g_chk
    $error("ipw_watchdog: BASE_LOG2 out of range");
  end

  logic [CW-1:0] cnt_reg;
  logic          armed_reg;
  logic          irq_reg;
  logic          rst_reg;
  logic [CW-1:0] interval;

  // Every ratio step multiplies the timeout by eight
  always_comb begin
    interval = CW'(1) << (BASE_LOG2 + WD_STEP_LOG2 * int'(wd.ratio_sel));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg   <= '0;
      armed_reg <= 1'b0;
      irq_reg   <= 1'b0;
      rst_reg   <= 1'b0;
    end else begin
      irq_reg <= 1'b0;
      rst_reg <= 1'b0;
      if (wd.restart) begin
        cnt_reg   <= '0;
        armed_reg <= 1'b0;
      end else if (!armed_reg && cnt_reg == interval - CW'(1)) begin
        irq_reg   <= 1'b1;
        cnt_reg   <= '0;
        armed_reg <= wd.reset_en;
      end else if (armed_reg && cnt_reg == CW'(WD_RST_LAG - 1)) begin
        rst_reg   <= 1'b1;
        cnt_reg   <= '0;
        armed_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  assign wd.irq_timeout   = irq_reg;
  assign wd.reset_timeout = rst_reg;
endmodule

// file: logic/ipw_top.sv
// Interrupt prioritisation with watchdog timeout source
`timescale 1ns/1ns
// Overview of operation
// - Five levels 4..0; level 4 only for power-fail.
// - Every other source has two priority bits, levels 3..0.
// - Enabled power-fail request always wins arbitration.
// - Equal levels resolved by fixed natural order, earliest wins.
// - Order: pf, ext0, tmr0, ext1, tmr1, ser0, tmr2, ser1, ext2-5, watchdog.
// - Each source presents its fixed vector address.
// - Power-fail flag and enable sit at watchdog control bits 4 and 5.
// - Pending flags set on their event regardless of enable.
// - Edge external flag cleared when its routine is vectored to.
// - Level external flag follows the pin.
// - Timer 0/1 overflow flags cleared when vectored to.
// - Default interrupt timeout 2^17 clocks, reset 512 clocks later.
// - Reset on nrst_i returns watchdog ratio to its default; a watchdog reset does not.
// - Two ratio bits at clock control 7:6; each step multiplies by 8.
// - Watchdog reset trails interrupt timeout by 512 system clocks.
// - Restart bit restarts interval; without reset, periodic timeouts.
module ipw_top #(
  parameter int WD_BASE_LOG2 = ipw_pkg::WD_BASE_LOG2
) (
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          nrst_i,
  // External interrupt pins, active low
  input  wire logic [ipw_pkg::IPW_NEXT-1:0]  ext_pin_n_i,
  input  wire logic [ipw_pkg::IPW_NEXT-1:0]  ext_edge_mode_i,
  // Peripheral events and software flag clears
  input  wire logic [ipw_pkg::IPW_NSRC-1:0]  src_event_i,
  input  wire logic [ipw_pkg::IPW_NSRC-1:0]  flag_clr_i,
  // Enables and priority bits for sources 1..12
  input  wire logic [ipw_pkg::IPW_NSRC-2:0]  irq_en_i,
  input  wire logic [ipw_pkg::IPW_NSRC-2:0]  prio_low_i,
  input  wire logic [ipw_pkg::IPW_NSRC-2:0]  prio_high_i,
  // Watchdog and clock control writes
  input  wire logic                          wd_ctrl_wr_i,
  input  wire logic [7:0]                    wd_ctrl_data_i,
  input  wire logic                          clk_ctrl_wr_i,
  input  wire logic [7:0]                    clk_ctrl_data_i,
  // Processor core handshake
  input  wire logic                          vector_ack_i,
  input  wire logic                          reti_i,
  output logic                               irq_req_o,
  output logic [7:0]                         vector_o,
  output logic [ipw_pkg::IPW_LVLW-1:0]       irq_level_o,
  // Status
  output logic [ipw_pkg::IPW_NSRC-1:0]       pending_o,
  output logic [7:0]                         watchdog_control_reg_o,
  output logic [1:0]                         watchdog_ratio_sel_o,
  output logic                               wd_reset_o
);
  import ipw_pkg::*;

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0]          rst_sync_reg;
  logic                rst_n;
  logic [IPW_NEXT-1:0] pin_s1_reg;
  logic [IPW_NEXT-1:0] pin_s2_reg;
  logic [IPW_NEXT-1:0] pin_prev_reg;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg   <= '1;
      pin_s2_reg   <= '1;
      pin_prev_reg <= '1;
    end else begin
      pin_s1_reg   <= ext_pin_n_i;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic       wd_rst_en_reg;
  logic       pf_en_reg;
  logic [1:0] ratio_reg;
  logic       restart_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wd_rst_en_reg <= 1'b0;
      pf_en_reg     <= 1'b0;
      restart_reg   <= 1'b0;
    end else begin
      restart_reg <= wd_ctrl_wr_i & wd_ctrl_data_i[WDC_RESTART];
      if (wd_ctrl_wr_i) begin
        wd_rst_en_reg <= wd_ctrl_data_i[WDC_RST_EN];
        pf_en_reg     <= wd_ctrl_data_i[WDC_PF_EN];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ratio_reg <= WD_RATIO_RST;
    end else if (clk_ctrl_wr_i) begin
      ratio_reg <= clk_ctrl_data_i[CKC_RATIO_LSB +: 2];
    end
  end

  // ----------------------------------------
  // Watchdog timer
  // ----------------------------------------
  ipw_wd_if wd_if ();
  assign wd_if.ratio_sel = ratio_reg;
  assign wd_if.restart   = restart_reg;
  assign wd_if.reset_en  = wd_rst_en_reg;

  ipw_watchdog #(
    .BASE_LOG2 (WD_BASE_LOG2)
  ) u_wd (
    .clk_i     (ref_clk_i),
    .rst_n_i   (rst_n),
    .wd        (wd_if)
  );

  // ----------------------------------------
  // Pending flags
  // ----------------------------------------
  logic [IPW_NSRC-1:0] flag_reg;
  logic [IPW_NSRC-1:0] set_ev;
  logic [IPW_NSRC-1:0] hw_clr;
  logic [IPW_NSRC-1:0] level_src;
  logic [IPW_NSRC-1:0] level_val;
  logic [3:0]          gnt_src_reg;
  logic                taken;

  assign taken = vector_ack_i & irq_req_o;

  always_comb begin
    set_ev    = src_event_i;
    hw_clr    = '0;
    level_src = '0;
    level_val = '0;
    set_ev[SRC_WD] = src_event_i[SRC_WD] | wd_if.irq_timeout;
    for (int k = 0; k < IPW_NEXT; k++) begin
      set_ev[IPW_EXT_SRC[k]] = ext_edge_mode_i[k] & pin_prev_reg[k] & ~pin_s2_reg[k];
      hw_clr[IPW_EXT_SRC[k]] = ext_edge_mode_i[k] & taken &
                               (int'(gnt_src_reg) == IPW_EXT_SRC[k]);
      level_src[IPW_EXT_SRC[k]] = ~ext_edge_mode_i[k];
      level_val[IPW_EXT_SRC[k]] = ~pin_s2_reg[k];
    end
    hw_clr[SRC_TM0] = taken & (int'(gnt_src_reg) == SRC_TM0);
    hw_clr[SRC_TM1] = taken & (int'(gnt_src_reg) == SRC_TM1);
  end

  for (genvar i = 0; i < IPW_NSRC; i++) begin : g_flag
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        flag_reg[i] <= 1'b0;
      end else if (level_src[i]) begin
        flag_reg[i] <= level_val[i];
      end else if (set_ev[i]) begin
        flag_reg[i] <= 1'b1;
      end else if (hw_clr[i] || flag_clr_i[i]) begin
        flag_reg[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  logic [IPW_NSRC-1:0] en_all;
  logic [IPW_LVLW-1:0] lvl      [IPW_NSRC];
  logic [IPW_LVLW-1:0] best_lvl;
  logic [3:0]          best_src;
  logic                best_vld;
  logic [4:0]          in_svc_reg;
  logic [IPW_LVLW-1:0] cur_lvl;
  logic                cur_vld;

  assign en_all = {irq_en_i, pf_en_reg};

  always_comb begin
    lvl[SRC_PF] = LVL_PF;
    for (int i = 1; i < IPW_NSRC; i++) begin
      lvl[i] = {1'b0, prio_high_i[i-1], prio_low_i[i-1]};
    end
  end

  // Strict compare keeps the earliest source on a tie
  always_comb begin
    best_lvl = '0;
    best_src = '0;
    best_vld = 1'b0;
    for (int i = 0; i < IPW_NSRC; i++) begin
      if (flag_reg[i] && en_all[i] && (!best_vld || lvl[i] > best_lvl)) begin
        best_lvl = lvl[i];
        best_src = 4'(i);
        best_vld = 1'b1;
      end
    end
  end

  always_comb begin
    cur_lvl = '0;
    cur_vld = 1'b0;
    for (int l = 0; l <= int'(LVL_PF); l++) begin
      if (in_svc_reg[l]) begin
        cur_lvl = IPW_LVLW'(l);
        cur_vld = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Core handshake
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_o   <= 1'b0;
      vector_o    <= '0;
      irq_level_o <= '0;
      gnt_src_reg <= '0;
    end else if (taken) begin
      irq_req_o <= 1'b0;
    end else begin
      irq_req_o   <= best_vld && (!cur_vld || best_lvl > cur_lvl);
      vector_o    <= IPW_VEC[best_src];
      irq_level_o <= best_lvl;
      gnt_src_reg <= best_src;
    end
  end

  // Service level stack: a return drops the highest active level
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      in_svc_reg <= '0;
    end else if (taken) begin
      in_svc_reg[irq_level_o] <= 1'b1;
    end else if (reti_i && cur_vld) begin
      in_svc_reg[cur_lvl] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pending_o              <= '0;
      watchdog_control_reg_o <= '0;
      watchdog_ratio_sel_o   <= WD_RATIO_RST;
      wd_reset_o             <= 1'b0;
    end else begin
      pending_o            <= flag_reg;
      watchdog_ratio_sel_o <= ratio_reg;
      wd_reset_o           <= wd_if.reset_timeout;
      watchdog_control_reg_o              <= '0;
      watchdog_control_reg_o[WDC_RST_EN]  <= wd_rst_en_reg;
      watchdog_control_reg_o[WDC_WD_FLAG] <= flag_reg[SRC_WD];
      watchdog_control_reg_o[WDC_PF_FLAG] <= flag_reg[SRC_PF];
      watchdog_control_reg_o[WDC_PF_EN]   <= pf_en_reg;
    end
  end
endmodule

// file: sim/ipw_core_model.sv
// Processor core stand-in that takes presented vectors when allowed
`timescale 1ns/1ns
module ipw_core_model (
  input  wire logic ref_clk_i,
  input  wire logic take_en_i,
  input  wire logic irq_req_i,
  output logic      vector_ack_o
);
  initial vector_ack_o = 1'b0;
  // One-cycle take, held until the sampling edge, then released
  always @(posedge ref_clk_i) begin
    vector_ack_o <= #1 take_en_i && irq_req_i && !vector_ack_o;
  end
endmodule

// file: sim/ipw_top_properties.sv
// Port-level properties of the interrupt priority and watchdog top
`timescale 1ns/1ns
module ipw_top_properties (
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic        wd_ctrl_wr_i,
  input wire logic [7:0]  wd_ctrl_data_i,
  input wire logic        clk_ctrl_wr_i,
  input wire logic [7:0]  clk_ctrl_data_i,
  input wire logic        vector_ack_i,
  input wire logic        irq_req_o,
  input wire logic [7:0]  vector_o,
  input wire logic [2:0]  irq_level_o,
  input wire logic [12:0] pending_o,
  input wire logic [7:0]  watchdog_control_reg_o,
  input wire logic [1:0]  watchdog_ratio_sel_o,
  input wire logic        wd_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_expire;
    $rose(pending_o[12]) && watchdog_control_reg_o[1];
  endsequence
  sequence s_reset_gap;
    !wd_reset_o [*8] ##[490:515] wd_reset_o;
  endsequence
  a_wd_reset_lag: assert property (s_expire |=> s_reset_gap)
    else $error("watchdog reset not 512 clocks after timeout");
  a_wd_reset_pulse: assert property (wd_reset_o |=> !wd_reset_o)
    else $error("watchdog reset longer than one cycle");
  a_top_level_pf: assert property (irq_req_o && irq_level_o == 3'h4 |-> vector_o == 8'h33)
    else $error("level 4 given to a source other than power-fail");
  a_other_level_max: assert property (irq_req_o && vector_o != 8'h33 |-> irq_level_o <= 3'h3)
    else $error("ordinary source above level 3");
  a_pf_always_wins: assert property ((pending_o[0] && watchdog_control_reg_o[5]) [*3]
    |-> !irq_req_o || irq_level_o == 3'h4)
    else $error("enabled power-fail request not presented");
  a_ack_drops_req: assert property (irq_req_o && vector_ack_i |=> !irq_req_o)
    else $error("request still up after vector taken");
  a_ratio_write: assert property (clk_ctrl_wr_i
    |-> ##2 watchdog_ratio_sel_o == $past(clk_ctrl_data_i[7:6], 2))
    else $error("watchdog ratio not taken from write");
  a_wdc_write: assert property (wd_ctrl_wr_i |-> ##2 {watchdog_control_reg_o[5],
    watchdog_control_reg_o[1]} == $past({wd_ctrl_data_i[5], wd_ctrl_data_i[1]}, 2))
    else $error("watchdog control enables not taken from write");
endmodule
bind ipw_top ipw_top_properties ipw_top_properties_i (.ref_clk_i(ref_clk_i),
  .nrst_i(nrst_i), .wd_ctrl_wr_i(wd_ctrl_wr_i), .wd_ctrl_data_i(wd_ctrl_data_i),
  .clk_ctrl_wr_i(clk_ctrl_wr_i), .clk_ctrl_data_i(clk_ctrl_data_i),
  .vector_ack_i(vector_ack_i), .irq_req_o(irq_req_o), .vector_o(vector_o),
  .irq_level_o(irq_level_o), .pending_o(pending_o),
  .watchdog_control_reg_o(watchdog_control_reg_o),
  .watchdog_ratio_sel_o(watchdog_ratio_sel_o), .wd_reset_o(wd_reset_o));

// file: sim/ipw_top_tb.sv
// Self-checking bench for the interrupt priority and watchdog block
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module ipw_top_tb;
  logic        clk, nrst, wr_wd, wr_ck, reti, take, ack, req, wdr;
  logic [5:0]  pin_n, edge_m;
  logic [12:0] ev, clr, pend;
  logic [11:0] en, pl, ph;
  logic [7:0]  wd_d, ck_d, vec, wdc;
  logic [2:0]  lvl;
  logic [1:0]  ratio;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [7:0]  exp_vec [13] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
                                8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
  ipw_top #(.WD_BASE_LOG2(10)) ipw_top_i (.ref_clk_i(clk), .nrst_i(nrst),
    .ext_pin_n_i(pin_n), .ext_edge_mode_i(edge_m), .src_event_i(ev), .flag_clr_i(clr),
    .irq_en_i(en), .prio_low_i(pl), .prio_high_i(ph), .wd_ctrl_wr_i(wr_wd),
    .wd_ctrl_data_i(wd_d), .clk_ctrl_wr_i(wr_ck), .clk_ctrl_data_i(ck_d),
    .vector_ack_i(ack), .reti_i(reti), .irq_req_o(req), .vector_o(vec),
    .irq_level_o(lvl), .pending_o(pend), .watchdog_control_reg_o(wdc),
    .watchdog_ratio_sel_o(ratio), .wd_reset_o(wdr));
  ipw_core_model ipw_core_model_i (.ref_clk_i(clk), .take_en_i(take), .irq_req_i(req),
    .vector_ack_o(ack));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_req();
    for (int k = 0; k < 40 && req !== 1'b1; k++) cyc(1);
    `CHK(req, 1'b1)
    if (req !== 1'b1) end_of_test();
  endtask
  task automatic wd_wr(input logic [7:0] d, input logic ck);
    {wd_d, ck_d} = {d, d};
    {wr_wd, wr_ck} = {!ck, ck};
    cyc(1);
    {wr_wd, wr_ck} = 2'h0;
    cyc(2);
  endtask
  task automatic trig(input int i);
    int p;
    p = (i == 1) ? 0 : (i == 3) ? 1 : i - 6;
    if (i == 1 || i == 3 || (i > 7 && i < 12)) begin
      pin_n[p] = 1'b0;
      cyc(2);
      pin_n[p] = 1'b1;
    end else begin
      ev[i] = 1'b1;
      cyc(1);
      ev[i] = 1'b0;
    end
  endtask
  task automatic clean();
    {take, en, pl, ph} = '0;
    clr = '1;
    cyc(1);
    clr = '0;
    reti = 1'b1;
    cyc(5);
    reti = 1'b0;
    cyc(3);
  endtask
  task automatic wait_wd(input int lo, input int hi);
    int k;
    clr[12] = 1'b1;
    cyc(1);
    clr[12] = 1'b0;
    // Status copy trails the flag by one edge
    cyc(1);
    for (k = 0; k < hi && pend[12] !== 1'b1; k++) cyc(1);
    `CHK(k >= lo && k < hi, 1'b1)
    `CHK(wdc[3], 1'b1)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_each();
    for (int i = 1; i < 13; i++) begin
      en = 12'h1 << (i - 1);
      take = 1'b1;
      trig(i);
      wait_req();
      `CHK(vec, exp_vec[i])
      cyc(4);
      `CHK(pend[i], !(i < 5 || (i > 7 && i < 12)))
      clean();
    end
  endtask
  task automatic t_pf();
    {en, pl, ph} = {12'h7ff, 24'hffffff};
    wd_wr(8'h20, 1'b0);
    ev = 13'h0005;
    cyc(1);
    ev = '0;
    wait_req();
    `CHK(vec, 8'h33)
    `CHK(lvl, 3'h4)
    `CHK(wdc[5:4], 2'h3)
    wd_wr(8'h00, 1'b0);
    clean();
  endtask
  task automatic t_order();
    ev = 13'h00a0;
    cyc(1);
    ev = '0;
    cyc(2);
    `CHK(pend[7:5], 3'h5)
    `CHK(req, 1'b0)
    {en, pl} = {12'h7ff, 12'hfff};
    wait_req();
    `CHK(vec, 8'h23)
    ph = 12'h040;
    cyc(3);
    `CHK(vec, 8'h3b)
    `CHK(lvl, 3'h3)
    clean();
  endtask
  task automatic t_preempt();
    {en, pl, ph, take} = {12'h072, 12'h030, 12'h002, 1'b1};
    trig(5);
    wait_req();
    cyc(3);
    ev = 13'h00c0;
    cyc(1);
    ev = '0;
    cyc(6);
    `CHK(req, 1'b0)
    trig(2);
    wait_req();
    `CHK(vec, 8'h0b)
    `CHK(lvl, 3'h2)
    clean();
  endtask
  task automatic t_level();
    {edge_m, pin_n} = {6'h3e, 6'h3e};
    cyc(5);
    `CHK(pend[1], 1'b1)
    pin_n = '1;
    cyc(5);
    `CHK(pend[1], 1'b0)
    edge_m = '1;
  endtask
  task automatic t_wd();
    int k;
    wd_wr(8'h03, 1'b0);
    wait_wd(1015, 1035);
    for (k = 0; k < 600 && wdr !== 1'b1; k++) cyc(1);
    `CHK(k > 500 && k < 520, 1'b1)
    wd_wr(8'h01, 1'b0);
    wait_wd(1015, 1035);
    wait_wd(1010, 1035);
    wd_wr(8'h40, 1'b1);
    `CHK(ratio, 2'h1)
    wd_wr(8'h01, 1'b0);
    wait_wd(8180, 8200);
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(3);
    `CHK(ratio, 2'h0)
    `CHK(wdc, 8'h00)
  endtask
  initial begin
    {nrst, wr_wd, wr_ck, reti, take, ev, clr, en, pl, ph, wd_d, ck_d} = '0;
    {pin_n, edge_m} = '1;
    cyc(4);
    nrst = 1'b1;
    cyc(3);
    `CHK(ratio, 2'h0)
    t_each();
    t_pf();
    t_order();
    t_preempt();
    t_level();
    t_wd();
    end_of_test();
  end
endmodule
